// File: scan_pkg.sv
// Constants for the boundary-scan test port: instruction codes, register
// lengths, cell positions, identification fields and TAP state codes.
// Assumes a single test-clock domain at the link and a core clock elsewhere.
package scan_pkg;

	// Instruction register
	localparam int IR_W = 3;
	localparam logic [IR_W-1:0] INS_EXTEST = 3'h0;
	localparam logic [IR_W-1:0] INS_IDCODE = 3'h1;
	localparam logic [IR_W-1:0] INS_SAMPLE = 3'h2;
	localparam logic [IR_W-1:0] INS_CLAMP = 3'h3;
	localparam logic [IR_W-1:0] INS_HIGHZ = 3'h4;
	localparam logic [IR_W-1:0] INS_BYPASS = 3'h7;
	// Fixed pattern loaded in Capture-IR; low two bits 01 as usual for scan
	localparam logic [IR_W-1:0] IR_CAPTURE_VAL = 3'h1;

	// Boundary register
	localparam int BSR_LEN = 126;
	localparam int BUS_DIR_CELL = 94;
	localparam int BUS_LO_CELL = 86;
	localparam logic [BSR_LEN-1:0] BUS_MASK = BSR_LEN'(8'hFF) << BUS_LO_CELL;
	localparam logic [BSR_LEN-1:0] BSR_RESET = '0;

	// Identification register layout, LSB first
	localparam int ID_W = 32;
	localparam int ID_MANUF_W = 11;
	localparam int ID_PART_W = 16;
	localparam int ID_VER_W = 4;
	localparam int ID_MANUF_POS = 1;
	localparam int ID_PART_POS = 12;
	localparam int ID_VER_POS = 28;

	// Synchroniser depth for every crossing
	localparam int SYNC_STAGES = 2;

	// TAP controller states
	typedef enum logic [3:0] {
		TAP_RESET = 4'h0,
		TAP_IDLE = 4'h1,
		TAP_SEL_DR = 4'h2,
		TAP_CAP_DR = 4'h3,
		TAP_SHIFT_DR = 4'h4,
		TAP_EXIT1_DR = 4'h5,
		TAP_PAUSE_DR = 4'h6,
		TAP_EXIT2_DR = 4'h7,
		TAP_UPD_DR = 4'h8,
		TAP_SEL_IR = 4'h9,
		TAP_CAP_IR = 4'hA,
		TAP_SHIFT_IR = 4'hB,
		TAP_EXIT1_IR = 4'hC,
		TAP_PAUSE_IR = 4'hD,
		TAP_EXIT2_IR = 4'hE,
		TAP_UPD_IR = 4'hF
	} tap_state_e;

endpackage

// File: boundary_scan_port.sv
// Boundary-scan test access port: TAP controller, instruction register,
// boundary, bypass and identification registers, and the pin multiplexer.
// Assumes the scan controller changes mode select and serial data away from
// the rising test-clock edge; pads resolve pinOut/pinOeN outside this block.
`timescale 1ns/1ps

module boundary_scan_port
	import scan_pkg::*;
#(
	parameter logic [BSR_LEN-1:0] OUT_CELLS = '0,
	parameter logic [ID_MANUF_W-1:0] MANUF_CODE = 11'h155, // Arbitrary value
	parameter logic [ID_PART_W-1:0] PART_CODE = 16'h1234, // Arbitrary value
	parameter logic [ID_VER_W-1:0] VERSION_CODE = 4'h1
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic test_clock_pin,
	input wire logic test_reset_n_pin,
	input wire logic test_mode_select_pin,
	input wire logic test_serial_in_pin,
	output logic test_serial_out_pin,
	output logic testSerialOutOeN,
	input wire logic [BSR_LEN-1:0] pinIn,
	input wire logic [BSR_LEN-1:0] funcOut,
	input wire logic [BSR_LEN-1:0] funcOeN,
	output logic [BSR_LEN-1:0] pinOut,
	output logic [BSR_LEN-1:0] pinOeN,
	output logic [BSR_LEN-1:0] coreIn,
	output logic [ID_W-1:0] idLatched
);

	// Instructions that put the boundary register in the serial path
	function automatic logic bsrSel(input logic [IR_W-1:0] ins);
		bsrSel = (ins == INS_SAMPLE) || (ins == INS_EXTEST);
	endfunction

	// Instructions under which the boundary latch owns the pins
	function automatic logic pinsFromLatch(input logic [IR_W-1:0] ins);
		pinsFromLatch = (ins == INS_EXTEST) || (ins == INS_CLAMP);
	endfunction

	localparam logic [ID_W-1:0] ID_WORD = {VERSION_CODE, PART_CODE, MANUF_CODE, 1'b1};

	// Test clock domain, rising edge
	tap_state_e tapState_r, tapState_nxt;
	logic [IR_W-1:0] irShift_r, irShift_nxt;
	logic [BSR_LEN-1:0] bsrShift_r, bsrShift_nxt;
	logic [ID_W-1:0] idShift_r, idShift_nxt;
	logic bypass_r, bypass_nxt;
	logic [BSR_LEN-1:0] pinMetaT_r, pinSyncT_r;
	// Test clock domain, falling edge
	logic [IR_W-1:0] irLatch_r, irLatch_nxt;
	logic [BSR_LEN-1:0] bsrLatch_r, bsrLatch_nxt;
	logic [ID_W-1:0] idLatch_r, idLatch_nxt;
	logic tdo_r, tdo_nxt;
	logic tdoOeN_r, tdoOeN_nxt;
	// Core clock domain
	logic [IR_W-1:0] irMetaC_r, irSyncC_r;
	logic [BSR_LEN-1:0] bsrMetaC_r, bsrSyncC_r;
	// Previous synchronised word and the word the pins actually use
	logic [IR_W-1:0] irHoldC_r, irCore_r, irCore_nxt;
	logic [BSR_LEN-1:0] bsrHoldC_r, bsrCore_r, bsrCore_nxt;
	logic [BSR_LEN-1:0] pinMetaC_r, pinSyncC_r;
	logic [BSR_LEN-1:0] pinOut_r, pinOut_nxt;
	logic [BSR_LEN-1:0] pinOeN_r, pinOeN_nxt;
	logic [BSR_LEN-1:0] testOeN;

	// TAP controller next state from mode select
	always_comb
	begin
		tapState_nxt = tapState_r;
		case (tapState_r)
			TAP_RESET: tapState_nxt = test_mode_select_pin ? TAP_RESET : TAP_IDLE;
			TAP_IDLE: tapState_nxt = test_mode_select_pin ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_DR: tapState_nxt = test_mode_select_pin ? TAP_SEL_IR : TAP_CAP_DR;
			TAP_CAP_DR: tapState_nxt = test_mode_select_pin ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_SHIFT_DR: tapState_nxt = test_mode_select_pin ? TAP_EXIT1_DR : TAP_SHIFT_DR;
			TAP_EXIT1_DR: tapState_nxt = test_mode_select_pin ? TAP_UPD_DR : TAP_PAUSE_DR;
			TAP_PAUSE_DR: tapState_nxt = test_mode_select_pin ? TAP_EXIT2_DR : TAP_PAUSE_DR;
			TAP_EXIT2_DR: tapState_nxt = test_mode_select_pin ? TAP_UPD_DR : TAP_SHIFT_DR;
			TAP_UPD_DR: tapState_nxt = test_mode_select_pin ? TAP_SEL_DR : TAP_IDLE;
			TAP_SEL_IR: tapState_nxt = test_mode_select_pin ? TAP_RESET : TAP_CAP_IR;
			TAP_CAP_IR: tapState_nxt = test_mode_select_pin ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_SHIFT_IR: tapState_nxt = test_mode_select_pin ? TAP_EXIT1_IR : TAP_SHIFT_IR;
			TAP_EXIT1_IR: tapState_nxt = test_mode_select_pin ? TAP_UPD_IR : TAP_PAUSE_IR;
			TAP_PAUSE_IR: tapState_nxt = test_mode_select_pin ? TAP_EXIT2_IR : TAP_PAUSE_IR;
			TAP_EXIT2_IR: tapState_nxt = test_mode_select_pin ? TAP_UPD_IR : TAP_SHIFT_IR;
			TAP_UPD_IR: tapState_nxt = test_mode_select_pin ? TAP_SEL_DR : TAP_IDLE;
			default: tapState_nxt = TAP_RESET;
		endcase
	end

	// Shift stages: capture and shift on the rising edge, LSB nearest the output
	always_comb
	begin
		irShift_nxt = irShift_r;
		bsrShift_nxt = bsrShift_r;
		idShift_nxt = idShift_r;
		bypass_nxt = bypass_r;
		case (tapState_r)
			TAP_CAP_IR: irShift_nxt = IR_CAPTURE_VAL;
			TAP_SHIFT_IR: irShift_nxt = {test_serial_in_pin, irShift_r[IR_W-1:1]};
			TAP_CAP_DR:
			begin
				if (bsrSel(irLatch_r))
				begin
					// Pads sampled; cell 94 has no pad, so it reloads its latch
					bsrShift_nxt = pinSyncT_r;
					bsrShift_nxt[BUS_DIR_CELL] = bsrLatch_r[BUS_DIR_CELL];
				end
				if (irLatch_r == INS_IDCODE)
					idShift_nxt = ID_WORD;
				bypass_nxt = 1'b0;
			end
			TAP_SHIFT_DR:
			begin
				if (bsrSel(irLatch_r))
					bsrShift_nxt = {test_serial_in_pin, bsrShift_r[BSR_LEN-1:1]};
				else if (irLatch_r == INS_IDCODE)
					idShift_nxt = {test_serial_in_pin, idShift_r[ID_W-1:1]};
				else
					bypass_nxt = test_serial_in_pin;
			end
			default:
			begin
				irShift_nxt = irShift_r;
			end
		endcase
	end

	// Rising-edge registers; test reset pin acts on the rising edge
	always_ff @(posedge test_clock_pin)
	begin
		pinMetaT_r <= pinIn;
		pinSyncT_r <= pinMetaT_r;
		if (!test_reset_n_pin)
		begin
			tapState_r <= TAP_RESET;
			irShift_r <= IR_CAPTURE_VAL;
			bsrShift_r <= BSR_RESET;
			idShift_r <= '0;
			bypass_r <= 1'b0;
		end
		else
		begin
			tapState_r <= tapState_nxt;
			irShift_r <= irShift_nxt;
			bsrShift_r <= bsrShift_nxt;
			idShift_r <= idShift_nxt;
			bypass_r <= bypass_nxt;
		end
	end

	// Falling-edge latches and serial output
	always_comb
	begin
		irLatch_nxt = irLatch_r;
		bsrLatch_nxt = bsrLatch_r;
		idLatch_nxt = idLatch_r;
		tdo_nxt = tdo_r;
		tdoOeN_nxt = 1'b1;
		case (tapState_r)
			TAP_RESET:
			begin
				irLatch_nxt = INS_IDCODE;
				bsrLatch_nxt = BSR_RESET;
			end
			TAP_UPD_IR: irLatch_nxt = irShift_r;
			TAP_UPD_DR:
			begin
				// Only a selected boundary register updates, so clamp holds steady
				if (bsrSel(irLatch_r))
					bsrLatch_nxt = bsrShift_r;
				if (irLatch_r == INS_IDCODE)
					idLatch_nxt = idShift_r;
			end
			TAP_SHIFT_IR:
			begin
				tdo_nxt = irShift_r[0];
				tdoOeN_nxt = 1'b0;
			end
			TAP_SHIFT_DR:
			begin
				tdoOeN_nxt = 1'b0;
				if (bsrSel(irLatch_r))
					tdo_nxt = bsrShift_r[0];
				else if (irLatch_r == INS_IDCODE)
					tdo_nxt = idShift_r[0];
				else
					tdo_nxt = bypass_r;
			end
			default:
			begin
				tdo_nxt = tdo_r;
			end
		endcase
	end

	// Falling edge: state already reset to Test-Logic-Reset by the rising edge
	always_ff @(negedge test_clock_pin)
	begin
		irLatch_r <= irLatch_nxt;
		bsrLatch_r <= bsrLatch_nxt;
		idLatch_r <= idLatch_nxt;
		tdo_r <= tdo_nxt;
		tdoOeN_r <= tdoOeN_nxt;
	end

	assign test_serial_out_pin = tdo_r;
	assign testSerialOutOeN = tdoOeN_r;
	assign idLatched = idLatch_r;

	// Settle filter for the multi-bit crossings: each bit is synchronised on
	// its own, so a latch caught mid-change could show a mixed word (011 to
	// 100 may read 000 for one edge and briefly select extest). A word is
	// accepted only once it has read the same on two core edges in a row.
	// Cost: pins follow a latch change two core edges later than a bare sync.
	always_comb
	begin
		irCore_nxt = irCore_r;
		bsrCore_nxt = bsrCore_r;
		if (irSyncC_r == irHoldC_r)
			irCore_nxt = irSyncC_r;
		if (bsrSyncC_r == bsrHoldC_r)
			bsrCore_nxt = bsrSyncC_r;
	end

	// Output enables under extest/clamp; bus direction from cell 94
	assign testOeN = ~(OUT_CELLS | (bsrCore_r[BUS_DIR_CELL] ? BUS_MASK : '0));

	// Core-side pin multiplexer, fed only by words that passed the filter;
	// under highz the values still follow the latch so leaving highz
	// does not flash stale data on the pins
	always_comb
	begin
		pinOut_nxt = funcOut;
		pinOeN_nxt = funcOeN;
		if (pinsFromLatch(irCore_r))
		begin
			pinOut_nxt = bsrCore_r;
			pinOeN_nxt = testOeN;
		end
		else if (irCore_r == INS_HIGHZ)
		begin
			pinOut_nxt = bsrCore_r;
			pinOeN_nxt = '1;
		end
	end

	// Core-domain crossings and pin registers
	always_ff @(posedge core_clk)
	begin
		irMetaC_r <= irLatch_r;
		irSyncC_r <= irMetaC_r;
		bsrMetaC_r <= bsrLatch_r;
		bsrSyncC_r <= bsrMetaC_r;
		irHoldC_r <= irSyncC_r;
		bsrHoldC_r <= bsrSyncC_r;
		pinMetaC_r <= pinIn;
		pinSyncC_r <= pinMetaC_r;
		if (!nrst)
		begin
			// Same words the latches take in Test-Logic-Reset
			irCore_r <= INS_IDCODE;
			bsrCore_r <= BSR_RESET;
			pinOut_r <= '0;
			pinOeN_r <= '1;
			coreIn <= '0;
		end
		else
		begin
			irCore_r <= irCore_nxt;
			bsrCore_r <= bsrCore_nxt;
			pinOut_r <= pinOut_nxt;
			pinOeN_r <= pinOeN_nxt;
			coreIn <= pinSyncC_r;
		end
	end

	assign pinOut = pinOut_r;
	assign pinOeN = pinOeN_r;

endmodule // boundary_scan_port

// File: boundary_scan_port_props.sv
// Checker for the scan port: input sync delay and serial-out behaviour after
// known mode-select walks. Assumes it is bound to boundary_scan_port.
`timescale 1ns/1ps

module boundary_scan_port_props
	import scan_pkg::*;
#(
	parameter logic [ID_MANUF_W-1:0] MANUF_CODE = 11'h155 // Arbitrary value
)
(
	input wire logic core_clk,
	input wire logic nrst,
	input wire logic test_clock_pin,
	input wire logic test_reset_n_pin,
	input wire logic test_mode_select_pin,
	input wire logic test_serial_out_pin,
	input wire logic testSerialOutOeN,
	input wire logic [BSR_LEN-1:0] pinIn,
	input wire logic [BSR_LEN-1:0] coreIn
);
	// Cell 94 has no pad, so its level is left out
	localparam logic [BSR_LEN-1:0] PAD_MASK = ~(BSR_LEN'(1) << BUS_DIR_CELL);

	property p_sync;
		@(posedge core_clk) disable iff (!nrst)
		nrst[*4] |-> ((coreIn ^ $past(pinIn, 3)) & PAD_MASK) == '0;
	endproperty
	property p_tlr_off;
		@(posedge test_clock_pin) disable iff (!test_reset_n_pin)
		test_mode_select_pin[*5] |=> testSerialOutOeN;
	endproperty
	property p_exit_off;
		@(posedge test_clock_pin) disable iff (!test_reset_n_pin)
		!testSerialOutOeN && test_mode_select_pin |=> testSerialOutOeN;
	endproperty
	property p_stay_on;
		@(posedge test_clock_pin) disable iff (!test_reset_n_pin)
		!testSerialOutOeN && !test_mode_select_pin |=> !testSerialOutOeN;
	endproperty
	// Walks from Test-Logic-Reset: each names the bit due on the wire
	sequence s_to_ir;
		test_mode_select_pin[*5] ##1 !test_mode_select_pin ##1 test_mode_select_pin[*2];
	endsequence
	sequence s_to_dr;
		test_mode_select_pin[*5] ##1 !test_mode_select_pin ##1 test_mode_select_pin;
	endsequence
	property p_ir_b0;
		@(posedge test_clock_pin) disable iff (!test_reset_n_pin)
		s_to_ir ##1 !test_mode_select_pin[*2] |=> !testSerialOutOeN && test_serial_out_pin;
	endproperty
	property p_ir_b1;
		@(posedge test_clock_pin) disable iff (!test_reset_n_pin)
		s_to_ir ##1 !test_mode_select_pin[*3] |=> !test_serial_out_pin;
	endproperty
	property p_id_b0;
		@(posedge test_clock_pin) disable iff (!test_reset_n_pin)
		s_to_dr ##1 !test_mode_select_pin[*2] |=> !testSerialOutOeN && test_serial_out_pin;
	endproperty
	property p_id_b1;
		@(posedge test_clock_pin) disable iff (!test_reset_n_pin)
		s_to_dr ##1 !test_mode_select_pin[*3] |=> test_serial_out_pin == MANUF_CODE[0];
	endproperty

	a_sync: assert property (p_sync) else $error("core input sync delay wrong");
	a_tlr_off: assert property (p_tlr_off) else $error("serial out driven in reset");
	a_exit_off: assert property (p_exit_off) else $error("serial out driven after shift");
	a_stay_on: assert property (p_stay_on) else $error("serial out dropped in shift");
	a_ir_b0: assert property (p_ir_b0) else $error("instruction capture bit 0 wrong");
	a_ir_b1: assert property (p_ir_b1) else $error("instruction capture bit 1 wrong");
	a_id_b0: assert property (p_id_b0) else $error("identification bit 0 wrong");
	a_id_b1: assert property (p_id_b1) else $error("identification bit 1 wrong");

	c_shift: cover property (@(posedge test_clock_pin) !testSerialOutOeN);
	c_tlr: cover property (@(posedge test_clock_pin) test_mode_select_pin[*5]);
	c_dr: cover property (@(posedge test_clock_pin) s_to_dr);
	c_ir: cover property (@(posedge test_clock_pin) s_to_ir);
endmodule // boundary_scan_port_props

bind boundary_scan_port boundary_scan_port_props #(.MANUF_CODE(MANUF_CODE)) u_props (.core_clk,
	.nrst, .test_clock_pin, .test_reset_n_pin, .test_mode_select_pin, .test_serial_out_pin,
	.testSerialOutOeN, .pinIn, .coreIn);

// File: scan_ctrl_model.sv
// Outside scan controller: clocks the link only while one of its tasks runs.
// Assumes the bench calls one task at a time.
`timescale 1ns/1ps

module scan_ctrl_model
	import scan_pkg::*;
(
	output logic tck,
	output logic trstN,
	output logic tms,
	output logic tdi,
	input wire logic tdo,
	input wire logic tdoOeN
);
	logic tdoSeen;
	// Released line reads as its pull-up level, never a stale bit
	wire tdoWire = tdoOeN ? 1'b1 : tdo;

	initial
	begin
		tck = 1'b0;
		trstN = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// One period; select and data change only while the clock is low
	task automatic step(input logic m, input logic d);
		tms = m;
		tdi = d;
		#7.5;
		tdoSeen = tdoWire;
		tck = 1'b1;
		#7.5;
		tck = 1'b0;
	endtask

	// Reset pin for one edge, five high selects, then park in Idle
	task automatic go_reset();
		trstN = 1'b0;
		step(1'b1, 1'b0);
		trstN = 1'b1;
		repeat (5) step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask

	// Full scan from Idle back to Idle, LSB first
	task automatic scan(input logic isIr, input int n, input logic [BSR_LEN-1:0] din,
		output logic [BSR_LEN-1:0] dout);
		dout = '0;
		step(1'b1, 1'b0);
		if (isIr)
			step(1'b1, 1'b0);
		step(1'b0, 1'b0);
		step(1'b0, 1'b0);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i]);
			dout[i] = tdoSeen;
		end
		step(1'b1, 1'b0);
		step(1'b0, 1'b0);
	endtask
endmodule // scan_ctrl_model

// File: boundary_scan_instructions_regs_tb_top.sv
// Bench for the scan port: instruction walk with pin and serial checks.
// Assumes scan_ctrl_model drives the link and pads hold fixed levels.
`timescale 1ns/1ps

module boundary_scan_instructions_regs_tb_top
	import scan_pkg::*;
;
	// Identification values are arbitrary
	localparam logic [ID_MANUF_W-1:0] MANUF = 11'h6B3;
	localparam logic [ID_PART_W-1:0] PART = 16'h5A0C;
	localparam logic [ID_VER_W-1:0] VER = 4'h9;
	localparam logic [BSR_LEN-1:0] PADS = {21{6'h2A}};
	localparam logic [BSR_LEN-1:0] F_OUT = {21{6'h15}};
	localparam logic [BSR_LEN-1:0] F_OEN = {21{6'h33}};
	localparam logic [BSR_LEN-1:0] DIR = BSR_LEN'(1) << BUS_DIR_CELL;
	localparam logic [BSR_LEN-1:0] PRE = (BSR_LEN'(8'hA5) << BUS_LO_CELL) | DIR | BSR_LEN'(16'hBEEF);
	localparam logic [BSR_LEN-1:0] OFF = ~BSR_LEN'(0);
	logic core_clk = 1'b0;
	logic nrst, tck, trstN, tms, tdi, tdo, tdoOeN;
	logic [BSR_LEN-1:0] pinOut, pinOeN, coreIn, got;
	logic [ID_W-1:0] idLatched;
	int error_cnt, comparisons;

	always #25 core_clk = ~core_clk;

	scan_ctrl_model ctl (.tck, .trstN, .tms, .tdi, .tdo, .tdoOeN);
	boundary_scan_port #(.MANUF_CODE(MANUF), .PART_CODE(PART), .VERSION_CODE(VER)) uut (
		.core_clk, .nrst, .test_clock_pin(tck), .test_reset_n_pin(trstN),
		.test_mode_select_pin(tms), .test_serial_in_pin(tdi), .test_serial_out_pin(tdo),
		.testSerialOutOeN(tdoOeN), .pinIn(PADS), .funcOut(F_OUT), .funcOeN(F_OEN), .pinOut,
		.pinOeN, .coreIn, .idLatched);

	task automatic check(input string what, input logic [BSR_LEN-1:0] seen, exp);
		comparisons++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Pins follow the latches five core edges late, so allow eight
	task automatic dr(input logic [BSR_LEN-1:0] din);
		ctl.scan(1'b0, BSR_LEN, din, got);
		repeat (8) @(negedge core_clk);
	endtask

	task automatic load(input logic [IR_W-1:0] code);
		ctl.scan(1'b1, IR_W, BSR_LEN'(code), got);
		check("ir capture", got, BSR_LEN'(IR_CAPTURE_VAL));
		repeat (8) @(negedge core_clk);
	endtask

	task automatic t_idcode();
		ctl.go_reset();
		ctl.scan(1'b0, ID_W, BSR_LEN'({VER, PART, MANUF, 1'h1}), got);
		check("id shift", got, BSR_LEN'({VER, PART, MANUF, 1'h1}));
		check("id latch", BSR_LEN'(idLatched), BSR_LEN'({VER, PART, MANUF, 1'h1}));
	endtask

	task automatic t_sample();
		load(INS_SAMPLE);
		dr(PRE);
		check("sample capture", got, PADS & ~DIR);
		check("func out", pinOut, F_OUT);
		check("func oe", pinOeN, F_OEN);
		check("core in", coreIn, PADS);
	endtask

	task automatic t_extest();
		load(INS_EXTEST);
		check("ext out", pinOut, PRE);
		check("ext oe", pinOeN, ~BUS_MASK);
		dr(PRE & ~DIR);
		check("ext capture", got, PADS | DIR);
		check("bus input", pinOeN, OFF);
		dr(PRE);
		check("ext capture", got, PADS & ~DIR);
	endtask

	// Mid-run test reset: idcode current again, latch cleared, pins back to
	// function; the preload after it sees cell 94 captured from a cleared latch
	task automatic t_reset();
		ctl.go_reset();
		repeat (8) @(negedge core_clk);
		check("reset out", pinOut, F_OUT);
		check("reset oe", pinOeN, F_OEN);
		load(INS_SAMPLE);
		dr(PRE);
		check("cleared capture", got, PADS & ~DIR);
	endtask

	task automatic t_one_bit();
		logic [IR_W-1:0] codes [3] = '{INS_CLAMP, INS_HIGHZ, INS_BYPASS};
		foreach (codes[i])
		begin
			load(codes[i]);
			dr(BSR_LEN'(2'h3));
			// Captured 0 leads, then the input one bit late
			check("one bit path", got, BSR_LEN'(3'h6));
			check("pin oe", pinOeN, codes[i] == INS_HIGHZ ? OFF
				: codes[i] == INS_CLAMP ? ~BUS_MASK : F_OEN);
			if (codes[i] != INS_HIGHZ)
				check("pin out", pinOut, codes[i] == INS_CLAMP ? PRE : F_OUT);
		end
	endtask

	task automatic wrap_up();
		if (error_cnt == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	// Whole run is about a thousand clocked link periods; this is ample
	initial
	begin
		#400000;
		error_cnt++;
		wrap_up();
	end

	initial
	begin
		nrst = 1'b0;
		error_cnt = 0;
		comparisons = 0;
		repeat (6) @(negedge core_clk);
		nrst = 1'b1;
		t_idcode();
		t_sample();
		t_extest();
		t_reset();
		t_one_bit();
		wrap_up();
	end
endmodule // boundary_scan_instructions_regs_tb_top
